//--- test/aisf_dma_host.sv
module aisf_dma_host #(
  parameter int LAT = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Request and data from the block
  input wire logic dma_req,
  input wire logic [15:0] dma_data,
  output logic dma_ack,
  // What the host collected
  output int n_words,
  output logic [15:0] first_word
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_cnt;
  logic take;

  // A slow host: the acknowledge comes only after LAT waiting cycles
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dma_ack <= 1'b0;
      wait_cnt <= 0;
      take <= 1'b0;
      n_words <= 0;
      first_word <= 16'h0000;
    end else begin
      take <= dma_req && dma_ack;
      // A finished word or a withdrawn request ends the acknowledge
      if (!dma_req || dma_ack) begin
        dma_ack <= 1'b0;
        wait_cnt <= 0;
      end else if (wait_cnt >= LAT) begin
        dma_ack <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
      // Word is valid the cycle after the acknowledged edge
      if (take) begin
        if (n_words == 0) begin
          first_word <= dma_data;
        end
        n_words <= n_words + 1;
      end
    end
  end
endmodule : aisf_dma_host

//--- test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] entry;
    logic [15:0] code;
    logic keep;
  } aisf_row_type;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic [7:0] AWADDR = 8'h00;
  logic [7:0] ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'hf;
  logic AWVALID = 1'b0;
  logic WVALID = 1'b0;
  logic BREADY = 1'b0;
  logic ARVALID = 1'b0;
  logic RREADY = 1'b0;
  logic ACQ_ACTIVE = 1'b0;
  logic CFG_ADVANCE = 1'b0;
  logic CFG_RETRANSMIT = 1'b0;
  logic RESULT_LOAD_STROBE = 1'b0;
  logic [15:0] ADC_CODE = 16'h0;
  logic DMA_DUE = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SCAN_END;
  logic DMA_REQ, DMA_ACK, INPUT_BUFFER_EMPTY_FLAG, HALF_FULL, FULL;
  logic [1:0] BRESP, RRESP, rr;
  logic [31:0] RDATA, rd;
  logic [15:0] DMA_DATA, host_first;
  logic [7:0] IRQ_OUT;
  aisf_pkg::aisf_front_type FRONT;
  logic [15:0] kept[$];
  aisf_row_type rows [5];
  int n_fail = 0;
  int tests_run = 0;
  int host_n;

  always #4 CLK = ~CLK;

  aisf_top DUT (
    .CLK, .RSTN, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
    .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
    .RDATA, .RRESP, .RVALID, .RREADY, .ACQ_ACTIVE, .CFG_ADVANCE,
    .CFG_RETRANSMIT, .RESULT_LOAD_STROBE, .ADC_CODE, .DMA_DUE, .FRONT,
    .SCAN_END, .DMA_REQ, .DMA_ACK, .DMA_DATA, .IRQ_OUT,
    .INPUT_BUFFER_EMPTY_FLAG, .HALF_FULL, .FULL
  );

  aisf_dma_host #(.LAT(3)) host (
    .clk(CLK), .rstn(RSTN), .dma_req(DMA_REQ), .dma_data(DMA_DATA),
    .dma_ack(DMA_ACK), .n_words(host_n), .first_word(host_first)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    // Each channel is released at the edge its own ready is seen
    while (!(aw_done && w_done)) begin
      @(posedge CLK);
      if (!aw_done && AWREADY) begin
        AWVALID <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && WREADY) begin
        WVALID <= 1'b0;
        w_done = 1'b1;
      end
    end
    while (!BVALID) @(posedge CLK);
    rr = BRESP;
    BREADY <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    @(posedge CLK);
    while (!ARREADY) @(posedge CLK);
    ARVALID <= 1'b0;
    while (!RVALID) @(posedge CLK);
    rd = RDATA;
    rr = RRESP;
    RREADY <= 1'b0;
  endtask : axr

  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    axr(a);
    check(rd & m, e);
  endtask : rchk

  task automatic settle;
    repeat (2) @(posedge CLK);
    #1;
  endtask : settle

  task automatic strb(input logic [15:0] c);
    @(posedge CLK);
    RESULT_LOAD_STROBE <= 1'b1;
    ADC_CODE <= c;
    @(posedge CLK);
    RESULT_LOAD_STROBE <= 1'b0;
    #1;
  endtask : strb

  task automatic adv;
    @(posedge CLK);
    CFG_ADVANCE <= 1'b1;
    @(posedge CLK);
    CFG_ADVANCE <= 1'b0;
    settle();
  endtask : adv

  // Front-end settings that an entry should produce on this variant
  function automatic logic [15:0] fexp(input logic [15:0] e);
    logic [2:0] g;
    g = e[11:9];
    if (g == aisf_pkg::GAIN_HALF) g = aisf_pkg::GAIN_1;
    if (g == aisf_pkg::GAIN_5) g = aisf_pkg::GAIN_2;
    return {e[6:4], e[8:7], e[3:0], g, e[12], 1'b1, e[14], e[15]};
  endfunction : fexp

  initial begin
    #100000;
    n_fail++;
    conclude();
  end

  initial begin
    rows[0] = '{16'h0001, 16'ha000, 1'b1};
    rows[1] = '{16'h1695, 16'ha001, 1'b1};
    rows[2] = '{16'h4e23, 16'ha002, 1'b1};
    rows[3] = '{16'h0442, 16'ha003, 1'b0};
    rows[4] = '{16'h8bbf, 16'ha004, 1'b1};
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    check({29'h0, INPUT_BUFFER_EMPTY_FLAG, HALF_FULL, FULL}, 32'h4);
    foreach (rows[i]) axw(aisf_pkg::ADDR_CFG_DATA, {16'h0, rows[i].entry});
    @(posedge CLK);
    ACQ_ACTIVE <= 1'b1;
    axw(aisf_pkg::ADDR_CFG_DATA, 32'h1);
    rchk(aisf_pkg::ADDR_COUNT, 32'h03ff0000, 32'h00050000);
    foreach (rows[i]) begin
      adv();
      check({16'h0, FRONT}, {16'h0, fexp(rows[i].entry)});
      strb(rows[i].code);
      check({31'h0, SCAN_END}, {31'h0, rows[i].entry[15]});
      if (rows[i].keep) kept.push_back(rows[i].code);
    end
    settle();
    check({31'h0, INPUT_BUFFER_EMPTY_FLAG}, 32'h0);
    rchk(aisf_pkg::ADDR_COUNT, 32'h3ff, 32'(kept.size()));
    while (kept.size() > 0) begin
      rchk(aisf_pkg::ADDR_RESULT, 32'hffff, {16'h0, kept.pop_front()});
    end
    rchk(aisf_pkg::ADDR_RESULT, 32'hffffffff, 32'h0);
    @(posedge CLK);
    CFG_RETRANSMIT <= 1'b1;
    @(posedge CLK);
    CFG_RETRANSMIT <= 1'b0;
    adv();
    check({16'h0, FRONT}, {16'h0, fexp(rows[0].entry)});
    for (int i = 0; i < 512; i++) begin
      strb(i[15:0]);
      if (i == 255) begin
        settle();
        check({30'h0, HALF_FULL, FULL}, 32'h2);
      end
    end
    settle();
    rchk(aisf_pkg::ADDR_STATUS, 32'h1f, 32'h0e);
    strb(16'hffff);
    settle();
    rchk(aisf_pkg::ADDR_STATUS, 32'h1f, 32'h1e);
    rchk(aisf_pkg::ADDR_COUNT, 32'h3ff, 32'd512);
    axw(aisf_pkg::ADDR_IRQ_CFG, 32'h2fb);
    settle();
    check({24'h0, IRQ_OUT}, 32'h88);
    rchk(aisf_pkg::ADDR_STATUS, 32'h1f, 32'h1e);
    axw(aisf_pkg::ADDR_CTRL, 32'h1);
    rchk(aisf_pkg::ADDR_STATUS, 32'h1f, 32'h0e);
    axw(aisf_pkg::ADDR_DMA_CFG, 32'h1);
    @(posedge CLK);
    DMA_DUE <= 1'b1;
    while (host_n < 3) @(posedge CLK);
    DMA_DUE <= 1'b0;
    repeat (4) settle();
    check({16'h0, host_first}, 32'h0);
    rchk(aisf_pkg::ADDR_COUNT, 32'h3ff, 32'(512 - host_n));
    // Three words went by DMA, so the fourth code is now the oldest
    rchk(aisf_pkg::ADDR_RESULT, 32'hffff, 32'h3);
    axr(8'h1c);
    check(rd, 32'h0);
    check({30'h0, rr}, {30'h0, aisf_pkg::RESP_SLVERR});
    axw(8'h1c, 32'h5);
    check({30'h0, rr}, {30'h0, aisf_pkg::RESP_SLVERR});
    axw(aisf_pkg::ADDR_CTRL, 32'h2);
    rchk(aisf_pkg::ADDR_COUNT, 32'h03ff0000, 32'h0);
    conclude();
  end
endmodule : tb_top

//--- verilog/aisf_pkg.sv
package aisf_pkg;
  localparam int CFG_DEPTH = 512;
  localparam int RES_DEPTH = 512;
  localparam int RES_HALF = 256;
  localparam logic RES_16BIT = 1'b1;
  localparam logic GAIN_LIMITED = 1'b1;
  localparam logic DITHER_FORCED = 1'b1;
  localparam logic [15:0] CODE_MASK_12 = 16'h0fff;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CFG_DATA = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0c;
  localparam logic [7:0] ADDR_DMA_CFG = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CFG = 8'h14;
  localparam logic [7:0] ADDR_COUNT = 8'h18;
  // Control bits (write one to act)
  localparam int CTRL_CLR_OVF = 0;
  localparam int CTRL_CLR_CFG = 1;
  // Status bits
  localparam int ST_EMPTY = 0;
  localparam int ST_NOT_EMPTY = 1;
  localparam int ST_HALF = 2;
  localparam int ST_FULL = 3;
  localparam int ST_OVF = 4;
  localparam int ST_CFG_EMPTY = 5;
  localparam int ST_CFG_FULL = 6;
  // Flag source codes for DMA and interrupt selection
  localparam logic [1:0] SRC_NOT_EMPTY = 2'h0;
  localparam logic [1:0] SRC_HALF = 2'h1;
  localparam logic [1:0] SRC_FULL = 2'h2;
  localparam logic [1:0] SRC_OVF = 2'h3;
  // Channel type codes
  localparam logic [2:0] TYPE_CAL = 3'h0;
  localparam logic [2:0] TYPE_DIFF = 3'h1;
  localparam logic [2:0] TYPE_RSE = 3'h2;
  localparam logic [2:0] TYPE_NRSE = 3'h3;
  localparam logic [2:0] TYPE_GHOST = 3'h4;
  // Gain codes: 0.5,1,2,5,10,20,50,100
  localparam logic [2:0] GAIN_HALF = 3'h0;
  localparam logic [2:0] GAIN_1 = 3'h1;
  localparam logic [2:0] GAIN_2 = 3'h2;
  localparam logic [2:0] GAIN_5 = 3'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic last;
    logic trigger;
    logic dither;
    logic bipolar;
    logic [2:0] gain;
    logic [1:0] bank;
    logic [2:0] chan_type;
    logic [3:0] chan;
  } aisf_entry_type;

  typedef struct packed {
    logic [2:0] mode;
    logic [5:0] select;
    logic [2:0] gain;
    logic bipolar;
    logic dither;
    logic trigger;
    logic last;
  } aisf_front_type;
endpackage : aisf_pkg

//--- verilog/aisf_top.sv
module aisf_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // AXI4-Lite slave
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Timing controller
  input wire logic ACQ_ACTIVE,
  input wire logic CFG_ADVANCE,
  input wire logic CFG_RETRANSMIT,
  input wire logic RESULT_LOAD_STROBE,
  input wire logic [15:0] ADC_CODE,
  input wire logic DMA_DUE,
  // Analog front end settings
  output aisf_pkg::aisf_front_type FRONT,
  output logic SCAN_END,
  // DMA and interrupt lines
  output logic DMA_REQ,
  input wire logic DMA_ACK,
  output logic [15:0] DMA_DATA,
  output logic [7:0] IRQ_OUT,
  // Result buffer flags
  output logic INPUT_BUFFER_EMPTY_FLAG,
  output logic HALF_FULL,
  output logic FULL
);
  logic rst_meta;
  logic rst_n;
  aisf_pkg::aisf_entry_type cfg_mem [aisf_pkg::CFG_DEPTH];
  logic [9:0] cfg_wr;
  logic [9:0] cfg_rd;
  aisf_pkg::aisf_entry_type cur;
  logic [15:0] res_mem [aisf_pkg::RES_DEPTH];
  logic [8:0] res_wr;
  logic [8:0] res_rd;
  logic [9:0] res_count;
  logic overflow;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] dma_cfg;
  logic [9:0] irq_cfg;
  logic wr_go;
  logic rd_go;
  logic cfg_push;
  logic cfg_empty;
  logic cfg_full;
  logic ghost;
  logic push;
  logic pop;
  logic dma_take;
  logic bus_pop;
  logic clr_ovf;
  logic not_empty;
  logic half;
  logic full;
  logic dma_src;
  logic irq_src;
  logic [15:0] next_code;

  function automatic logic flag_sel(input logic [1:0] sel,
      input logic ne, input logic hf, input logic fl, input logic ov);
    case (sel)
      aisf_pkg::SRC_NOT_EMPTY: flag_sel = ne;
      aisf_pkg::SRC_HALF: flag_sel = hf;
      aisf_pkg::SRC_FULL: flag_sel = fl;
      default: flag_sel = ov;
    endcase
  endfunction : flag_sel

  // Restricted variants lack 0.5 and 5; take a neighbouring gain
  function automatic logic [2:0] gain_map(input logic [2:0] g);
    if (aisf_pkg::GAIN_LIMITED && g == aisf_pkg::GAIN_HALF) begin
      gain_map = aisf_pkg::GAIN_1;
    end else if (aisf_pkg::GAIN_LIMITED && g == aisf_pkg::GAIN_5) begin
      gain_map = aisf_pkg::GAIN_2;
    end else begin
      gain_map = g;
    end
  endfunction : gain_map

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Bus write: address and data may come in either order
  assign AWREADY = !aw_held && !BVALID;
  assign WREADY = !w_held && !BVALID;
  assign wr_go = aw_held && w_held && !BVALID;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      BVALID <= 1'b0;
      BRESP <= aisf_pkg::RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        w_data <= WDATA;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        BVALID <= 1'b1;
        case (aw_addr)
          aisf_pkg::ADDR_CTRL, aisf_pkg::ADDR_CFG_DATA,
          aisf_pkg::ADDR_DMA_CFG, aisf_pkg::ADDR_IRQ_CFG:
            BRESP <= aisf_pkg::RESP_OKAY;
          default: BRESP <= aisf_pkg::RESP_SLVERR;
        endcase
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // Sequence words written during acquisition are dropped
  assign cfg_push = wr_go && aw_addr == aisf_pkg::ADDR_CFG_DATA &&
      !ACQ_ACTIVE && !cfg_full;
  assign clr_ovf = wr_go && aw_addr == aisf_pkg::ADDR_CTRL &&
      w_data[aisf_pkg::CTRL_CLR_OVF];

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      dma_cfg <= 4'h0;
      irq_cfg <= 10'h000;
    end else if (wr_go && aw_addr == aisf_pkg::ADDR_DMA_CFG) begin
      dma_cfg <= w_data[3:0];
    end else if (wr_go && aw_addr == aisf_pkg::ADDR_IRQ_CFG) begin
      irq_cfg <= w_data[9:0];
    end
  end

  // Sequence memory
  assign cfg_empty = cfg_rd == cfg_wr;
  assign cfg_full = cfg_wr == 10'(aisf_pkg::CFG_DEPTH);

  always_ff @(posedge CLK) begin
    if (cfg_push) begin
      cfg_mem[cfg_wr[8:0]] <= aisf_pkg::aisf_entry_type'(w_data[15:0]);
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_wr <= 10'h000;
      cfg_rd <= 10'h000;
      cur <= '0;
    end else if (wr_go && aw_addr == aisf_pkg::ADDR_CTRL &&
        w_data[aisf_pkg::CTRL_CLR_CFG]) begin
      cfg_wr <= 10'h000;
      cfg_rd <= 10'h000;
    end else begin
      if (cfg_push) begin
        cfg_wr <= cfg_wr + 10'h001;
      end
      if (CFG_RETRANSMIT && cfg_empty) begin
        cfg_rd <= 10'h000;
      end else if (CFG_ADVANCE && !cfg_empty) begin
        cur <= cfg_mem[cfg_rd[8:0]];
        cfg_rd <= cfg_rd + 10'h001;
      end
    end
  end

  // Front-end settings follow the current entry
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      FRONT <= '0;
      SCAN_END <= 1'b0;
    end else begin
      FRONT.mode <= cur.chan_type;
      FRONT.select <= {cur.bank, cur.chan};
      FRONT.gain <= gain_map(cur.gain);
      FRONT.bipolar <= cur.bipolar;
      FRONT.dither <= cur.dither || aisf_pkg::DITHER_FORCED;
      FRONT.trigger <= cur.trigger;
      FRONT.last <= cur.last;
      SCAN_END <= RESULT_LOAD_STROBE && cur.last;
    end
  end

  // Result buffer
  assign ghost = cur.chan_type == aisf_pkg::TYPE_GHOST;
  assign full = res_count == 10'(aisf_pkg::RES_DEPTH);
  assign push = RESULT_LOAD_STROBE && !ghost && !full;
  assign not_empty = res_count != 10'h000;
  assign half = res_count >= 10'(aisf_pkg::RES_HALF);
  assign dma_take = DMA_REQ && DMA_ACK;
  assign rd_go = ARVALID && ARREADY;
  assign bus_pop = rd_go && ARADDR == aisf_pkg::ADDR_RESULT && not_empty;
  assign pop = (dma_take && not_empty) || bus_pop;
  // Twelve-bit variants keep only the low code bits
  assign next_code = aisf_pkg::RES_16BIT ? ADC_CODE :
      (ADC_CODE & aisf_pkg::CODE_MASK_12);

  always_ff @(posedge CLK) begin
    if (push) begin
      res_mem[res_wr] <= next_code;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      res_wr <= 9'h000;
      res_rd <= 9'h000;
      res_count <= 10'h000;
    end else begin
      if (push) begin
        res_wr <= res_wr + 9'h001;
      end
      if (pop) begin
        res_rd <= res_rd + 9'h001;
      end
      case ({push, pop})
        2'b10: res_count <= res_count + 10'h001;
        2'b01: res_count <= res_count - 10'h001;
        default: res_count <= res_count;
      endcase
    end
  end

  // A new overflow in the clearing cycle wins over the clear
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      overflow <= 1'b0;
    end else if (RESULT_LOAD_STROBE && !ghost && full) begin
      overflow <= 1'b1;
    end else if (clr_ovf) begin
      overflow <= 1'b0;
    end
  end

  // Flags come from the count register, so they move the clock after a pop
  assign INPUT_BUFFER_EMPTY_FLAG = !not_empty;
  assign HALF_FULL = half;
  assign FULL = full;

  // DMA: one 16-bit word per acknowledge
  assign dma_src = flag_sel(dma_cfg[2:1], not_empty, half, full, 1'b0);
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      DMA_REQ <= 1'b0;
      DMA_DATA <= 16'h0000;
    end else begin
      if (dma_take) begin
        DMA_DATA <= res_mem[res_rd];
        DMA_REQ <= 1'b0;
      end else begin
        DMA_REQ <= dma_cfg[0] && DMA_DUE && dma_src && not_empty;
      end
    end
  end

  // Interrupt routing to one or two of the eight lines
  assign irq_src = flag_sel(irq_cfg[9:8], not_empty, half, full, overflow);
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ_OUT <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        IRQ_OUT[i] <= irq_src &&
            ((irq_cfg[3] && irq_cfg[2:0] == 3'(i)) ||
             (irq_cfg[7] && irq_cfg[6:4] == 3'(i)));
      end
    end
  end

  // Bus read; every read waits while DMA takes a word
  assign ARREADY = !RVALID && !dma_take;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= aisf_pkg::RESP_OKAY;
    end else if (rd_go) begin
      RVALID <= 1'b1;
      RRESP <= aisf_pkg::RESP_OKAY;
      case (ARADDR)
        aisf_pkg::ADDR_CTRL: RDATA <= 32'h0000_0000;
        aisf_pkg::ADDR_STATUS: RDATA <= {25'h0000000, cfg_full, cfg_empty,
            overflow, full, half, not_empty, !not_empty};
        aisf_pkg::ADDR_CFG_DATA: RDATA <= {16'h0000, cur};
        aisf_pkg::ADDR_RESULT: RDATA <= not_empty ?
            {16'h0000, res_mem[res_rd]} : 32'h0000_0000;
        aisf_pkg::ADDR_DMA_CFG: RDATA <= {28'h0000000, dma_cfg};
        aisf_pkg::ADDR_IRQ_CFG: RDATA <= {22'h000000, irq_cfg};
        aisf_pkg::ADDR_COUNT: RDATA <= {6'h00, cfg_wr, 6'h00, res_count};
        default: begin
          RDATA <= 32'h0000_0000;
          RRESP <= aisf_pkg::RESP_SLVERR;
        end
      endcase
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  a_ghost_no_store: assert property (
    RESULT_LOAD_STROBE && ghost && !pop |=> $stable(res_count))
    else $error("ghost result was stored");
  a_push_counts: assert property (
    RESULT_LOAD_STROBE && !ghost && !full && !pop |=>
    res_count == $past(res_count) + 10'h001)
    else $error("result not stored");
  a_overflow_set: assert property (
    RESULT_LOAD_STROBE && !ghost && full && !pop |=> overflow && full)
    else $error("overflow missed");
  a_overflow_hold: assert property (
    overflow && !clr_ovf |=> overflow)
    else $error("overflow dropped");
  a_empty_clears: assert property (
    INPUT_BUFFER_EMPTY_FLAG && push |=> !INPUT_BUFFER_EMPTY_FLAG)
    else $error("empty flag stuck");
  a_retransmit_rewind: assert property (
    CFG_RETRANSMIT && cfg_empty |=> cfg_rd == 10'h000)
    else $error("retransmit failed");
  a_scan_end_last: assert property (
    RESULT_LOAD_STROBE && cur.last |=> SCAN_END)
    else $error("scan did not end");
  a_dma_needs_due: assert property (
    $rose(DMA_REQ) |-> $past(DMA_DUE) && $past(dma_cfg[0]))
    else $error("unrequested DMA");
  a_dither_forced: assert property (
    ##1 aisf_pkg::DITHER_FORCED |-> FRONT.dither)
    else $error("dither off");
  a_full_flag: assert property (
    res_count == 10'(aisf_pkg::RES_DEPTH) |-> FULL && HALF_FULL)
    else $error("full flag wrong");

  c_overflow: cover property (RESULT_LOAD_STROBE && !ghost && full);
  c_ghost: cover property (RESULT_LOAD_STROBE && ghost);
  c_dma_word: cover property (dma_take);
  c_retransmit: cover property (CFG_RETRANSMIT && cfg_empty);
endmodule : aisf_top
